/* File: rtl/sfw_window.v */
// Socket transmit and receive windows into packet memory
`timescale 1ns/1ns
`include "sfw_consts.vh"
module sfw_window #(
   parameter AW = 12                      // Word address width of each memory
) (
   input  wire        clk_sys,            // System clock
   input  wire        rst_n,              // Async reset, active low
   input  wire [15:0] host_addr,          // Host byte address
   input  wire        host_wr,            // Host write strobe
   input  wire        host_rd,            // Host read strobe
   input  wire [15:0] host_wdata,         // Host write data
   output reg  [15:0] host_rdata,         // Host read data
   input  wire [16:0] tx_write_size,      // Bytes to send
   output reg  [7:0]  tx_out_byte,        // Outgoing byte
   output wire        tx_out_valid,       // Outgoing byte valid
   input  wire        tx_out_ready,       // Outgoing byte taken
   output wire        tx_busy,            // Send in progress
   input  wire        rx_pkt_start,       // New packet announce
   input  wire [15:0] rx_pkt_len,         // Packet byte count
   input  wire [47:0] rx_pkt_info,        // Peer address and port
   input  wire [7:0]  rx_in_byte,         // Incoming byte
   input  wire        rx_in_valid,        // Incoming byte valid
   output wire        rx_in_ready,        // Incoming byte taken
   output wire        rx_busy,            // Packet store in progress
   output reg         rx_pkt_done,        // Packet fully stored
   output reg         rx_size_dec2,       // Received size minus two
   output reg         rx_done_cmd         // Receive-done command
);
   localparam [1:0] TX_IDLE = 2'd0, TX_LOAD = 2'd1, TX_HI = 2'd2, TX_LO = 2'd3;
   localparam [1:0] RX_IDLE = 2'd0, RX_HDR = 2'd1, RX_DATA = 2'd2, RX_PAD = 2'd3;
   localparam [15:0] TXW = `SFW_TX_WIN;
   localparam [15:0] RXW = `SFW_RX_WIN;
   localparam [15:0] MDW = `SFW_MODE_REG;
   localparam [15:0] SMW = `SFW_SOCK_MODE_REG;
   localparam [15:0] CMW = `SFW_CMD_REG;

   reg  [15:0]   mode_reg;                // Bus width and memory test
   reg  [15:0]   sock_mode;               // Protocol mode and alignment
   reg  [7:0]    wr_hold;                 // Low byte awaiting its partner
   reg  [7:0]    rd_hold;                 // High byte held for 8-bit read
   reg  [AW-1:0] tx_wr_ptr;
   reg  [AW-1:0] tx_rd_ptr;
   reg  [AW-1:0] rx_wr_ptr;
   reg  [AW-1:0] rx_rd_ptr;
   reg  [1:0]    tx_state;
   reg  [16:0]   tx_left;                 // Bytes still to send
   reg  [7:0]    tx_lo;
   reg  [1:0]    rx_state;
   reg  [15:0]   rx_len;
   reg  [15:0]   rx_cnt;
   reg  [47:0]   rx_info;
   reg  [3:0]    hdr_len;
   reg  [3:0]    hdr_idx;
   reg  [7:0]    fill_hold;
   reg           fill_phase;              // One byte of a word held
   reg  [3:0]    next_hdr_len;
   reg  [7:0]    hdr_byte;
   reg  [15:0]   next_rdata;
   wire [15:0]   tx_q;
   wire [15:0]   rx_q;

   wire bus16 = mode_reg[`SFW_BIT_DBW];
   wire mt    = mode_reg[`SFW_BIT_MT];
   wire a0    = host_addr[0];
   // commit on high byte or full word
   wire commit = bus16 | a0;
   wire hit_tx = host_addr[15:1] == TXW[15:1];
   wire hit_rx = host_addr[15:1] == RXW[15:1];
   wire hit_md = host_addr[15:1] == MDW[15:1];
   wire hit_sm = host_addr[15:1] == SMW[15:1];
   wire hit_cm = host_addr[15:1] == CMW[15:1];
   // MSB is the earlier memory byte
   wire [15:0] host_word = bus16 ? host_wdata : {wr_hold, host_wdata[7:0]};

   wire tx_we = host_wr & hit_tx & commit;
   wire tx_rd_ok = host_rd & hit_tx & mt & (tx_state == TX_IDLE);
   // receive writes only in test mode
   wire rx_host_hit = host_wr & hit_rx & mt;
   wire rx_host_we = rx_host_hit & commit;
   // receive reads advance on a word
   wire rx_adv = host_rd & hit_rx & commit;
   wire tx_adv = tx_rd_ok & commit;

   // send command, 16-bit or high byte
   wire send_cmd = host_wr & hit_cm & (bus16 ? (host_wdata == `SFW_CMD_SEND16)
                                       : (a0 & (host_wdata[7:0] == `SFW_CMD_SEND8)));
   wire receive_done_cmd_cmd = host_wr & hit_cm & (bus16 ? (host_wdata == `SFW_CMD_RECV16)
                                       : (a0 & (host_wdata[7:0] == `SFW_CMD_RECV8)));

   // Fill byte source and word writer
   wire       fill_go   = (rx_state == RX_DATA) ? (rx_in_valid & ~rx_host_hit)
                        : ((rx_state != RX_IDLE) & ~rx_host_hit);
   wire [7:0] fill_byte = (rx_state == RX_DATA) ? rx_in_byte
                        : ((rx_state == RX_HDR) ? hdr_byte : 8'h00);
   wire       fill_we   = fill_go & fill_phase;
   wire       rx_we     = rx_host_we | fill_we;
   wire [15:0] rx_wd    = rx_host_we ? host_word : {fill_hold, fill_byte};

   assign rx_in_ready  = (rx_state == RX_DATA) & ~rx_host_hit;
   assign rx_busy      = rx_state != RX_IDLE;
   assign tx_out_valid = (tx_state == TX_HI) | (tx_state == TX_LO);
   assign tx_busy      = tx_state != TX_IDLE;

   sfw_mem #(.AW(AW), .DW(16)) u_tx_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (tx_we),
      .waddr   (tx_wr_ptr),
      .wdata   (host_word),
      .raddr   (tx_rd_ptr),
      .rdata   (tx_q)
   );

   sfw_mem #(.AW(AW), .DW(16)) u_rx_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (rx_we),
      .waddr   (rx_wr_ptr),
      .wdata   (rx_wd),
      .raddr   (rx_rd_ptr),
      .rdata   (rx_q)
   );

   always @* begin
      case (sock_mode[3:0])
         `SFW_PROTO_TCP:    next_hdr_len = `SFW_HDR_TCP;
         `SFW_PROTO_UDP:    next_hdr_len = `SFW_HDR_UDP;
         `SFW_PROTO_IPRAW:  next_hdr_len = `SFW_HDR_IPRAW;
         `SFW_PROTO_MACRAW: next_hdr_len = `SFW_HDR_MACRAW;
         default:           next_hdr_len = 4'h0;
      endcase
      if (sock_mode[3:0] == `SFW_PROTO_TCP && sock_mode[`SFW_BIT_ALIGN]) begin
         next_hdr_len = 4'h0;
      end
   end

   // header bytes, peer info then size
   always @* begin
      if (hdr_idx == hdr_len - 4'h2) begin
         hdr_byte = rx_len[15:8];
      end else if (hdr_idx == hdr_len - 4'h1) begin
         hdr_byte = rx_len[7:0];
      end else begin
         case (hdr_idx)
            4'h0:    hdr_byte = rx_info[47:40];
            4'h1:    hdr_byte = rx_info[39:32];
            4'h2:    hdr_byte = rx_info[31:24];
            4'h3:    hdr_byte = rx_info[23:16];
            4'h4:    hdr_byte = rx_info[15:8];
            default: hdr_byte = rx_info[7:0];
         endcase
      end
   end

   // Host read data selection
   always @* begin
      next_rdata = 16'h0000;
      if (hit_tx) begin
         next_rdata = mt ? tx_q : 16'h0000;
      end else if (hit_rx) begin
         next_rdata = rx_q;
      end else if (hit_md) begin
         next_rdata = mode_reg;
      end else if (hit_sm) begin
         next_rdata = sock_mode;
      end
   end

   // Host registers, holds and read port
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg     <= `SFW_MODE_RST;
         sock_mode    <= `SFW_SOCK_MODE_RST;
         wr_hold      <= 8'h00;
         rd_hold      <= 8'h00;
         host_rdata   <= 16'h0000;
         rx_size_dec2 <= 1'b0;
         rx_done_cmd  <= 1'b0;
      end else begin
         rx_size_dec2 <= 1'b0;
         rx_done_cmd  <= 1'b0;
         if (host_wr) begin
            // low byte waits for its partner
            if (!bus16 && !a0) begin
               wr_hold <= host_wdata[7:0];
            end
            if (hit_md) begin
               mode_reg <= bus16 ? host_wdata : (a0 ? {mode_reg[15:8], host_wdata[7:0]}
                                                    : {host_wdata[7:0], mode_reg[7:0]});
            end
            if (hit_sm) begin
               sock_mode <= bus16 ? host_wdata : (a0 ? {sock_mode[15:8], host_wdata[7:0]}
                                                     : {host_wdata[7:0], sock_mode[7:0]});
            end
            rx_done_cmd <= receive_done_cmd_cmd;
         end
         if (host_rd) begin
            if (bus16) begin
               host_rdata <= next_rdata;
            end else if (!a0) begin
               host_rdata <= {8'h00, next_rdata[15:8]};
               rd_hold    <= next_rdata[7:0];
            end else if (hit_tx || hit_rx) begin
               host_rdata <= {8'h00, rd_hold};
            end else begin
               host_rdata <= {8'h00, next_rdata[7:0]};
            end
         end
         rx_size_dec2 <= rx_adv;
      end
   end

   // Window pointers on the host side
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_wr_ptr <= {AW{1'b0}};
         rx_rd_ptr <= {AW{1'b0}};
      end else begin
         if (tx_we) begin
            tx_wr_ptr <= tx_wr_ptr + 1'b1;
         end
         if (rx_adv) begin
            rx_rd_ptr <= rx_rd_ptr + 1'b1;
         end
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_state    <= TX_IDLE;
         tx_left     <= 17'h00000;
         tx_rd_ptr   <= {AW{1'b0}};
         tx_out_byte <= 8'h00;
         tx_lo       <= 8'h00;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (tx_adv) begin
                  tx_rd_ptr <= tx_rd_ptr + 1'b1;
               end
               if (send_cmd && tx_write_size != 17'h00000) begin
                  tx_left  <= tx_write_size;
                  tx_state <= TX_LOAD;
               end
            end
            TX_LOAD: begin
               tx_out_byte <= tx_q[15:8];
               tx_lo       <= tx_q[7:0];
               tx_rd_ptr   <= tx_rd_ptr + 1'b1;
               tx_state    <= TX_HI;
            end
            TX_HI: begin
               if (tx_out_ready) begin
                  tx_left     <= tx_left - 17'h00001;
                  tx_out_byte <= tx_lo;
                  tx_state    <= (tx_left == 17'h00001) ? TX_IDLE : TX_LO;
               end
            end
            TX_LO: begin
               if (tx_out_ready) begin
                  tx_left  <= tx_left - 17'h00001;
                  tx_state <= (tx_left == 17'h00001) ? TX_IDLE : TX_LOAD;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Packet store: header, data, pad
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_state    <= RX_IDLE;
         rx_len      <= 16'h0000;
         rx_cnt      <= 16'h0000;
         rx_info     <= 48'h000000000000;
         hdr_len     <= 4'h0;
         hdr_idx     <= 4'h0;
         fill_hold   <= 8'h00;
         fill_phase  <= 1'b0;
         rx_wr_ptr   <= {AW{1'b0}};
         rx_pkt_done <= 1'b0;
      end else begin
         rx_pkt_done <= 1'b0;
         if (rx_we) begin
            rx_wr_ptr <= rx_wr_ptr + 1'b1;
         end
         if (fill_go) begin
            fill_phase <= ~fill_phase;
            if (!fill_phase) begin
               fill_hold <= fill_byte;
            end
         end
         case (rx_state)
            RX_IDLE: begin
               if (rx_pkt_start) begin
                  rx_len  <= rx_pkt_len;
                  rx_info <= rx_pkt_info;
                  hdr_len <= next_hdr_len;
                  hdr_idx <= 4'h0;
                  rx_cnt  <= 16'h0000;
                  if (next_hdr_len != 4'h0) begin
                     rx_state <= RX_HDR;
                  end else if (rx_pkt_len != 16'h0000) begin
                     rx_state <= RX_DATA;
                  end else begin
                     rx_pkt_done <= 1'b1;
                  end
               end
            end
            RX_HDR: begin
               if (fill_go) begin
                  hdr_idx <= hdr_idx + 4'h1;
                  if (hdr_idx == hdr_len - 4'h1) begin
                     rx_state    <= (rx_len != 16'h0000) ? RX_DATA : RX_IDLE;
                     rx_pkt_done <= (rx_len == 16'h0000);
                  end
               end
            end
            RX_DATA: begin
               if (fill_go) begin
                  rx_cnt <= rx_cnt + 16'h0001;
                  if (rx_cnt == rx_len - 16'h0001) begin
                     // odd count gets a pad byte
                     rx_state    <= rx_len[0] ? RX_PAD : RX_IDLE;
                     rx_pkt_done <= ~rx_len[0];
                  end
               end
            end
            RX_PAD: begin
               if (fill_go) begin
                  rx_state    <= RX_IDLE;
                  rx_pkt_done <= 1'b1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end
endmodule // sfw_window

/* File: rtl/sfw_consts.vh */
// Constants for the socket packet-memory window block
//
// Summary of operation
// - Memory test on: transmit window reads allowed
// - Transmit writes append, low byte first
// - Send drains memory in ascending order
// - Send command 0x0020 or high byte 0x20
// - Bus-width bit one selects 16-bit bus
// - Word MSB is the earlier memory byte
// - Memory test off: receive window read-only
// - Receive read gives next two bytes, advances
// - Header with size precedes each packet in the four protocol modes, except TCP with alignment
// - Odd packet padded with one byte
// - Header 2 TCP/raw-MAC, 8 UDP, 6 raw-IP
// - Received size drops two per word read
// - TCP with alignment stores no header
`ifndef SFW_CONSTS_VH
`define SFW_CONSTS_VH
`define SFW_MODE_REG      16'h0000
`define SFW_SOCK_MODE_REG 16'h8200
`define SFW_CMD_REG       16'h8202
`define SFW_TX_WIN        16'h822e
`define SFW_RX_WIN        16'h8230
`define SFW_BIT_DBW       15
`define SFW_BIT_MT        5
`define SFW_BIT_ALIGN     8
`define SFW_MODE_RST      16'h8000
`define SFW_SOCK_MODE_RST 16'h0000
`define SFW_CMD_SEND16    16'h0020
`define SFW_CMD_SEND8     8'h20
`define SFW_CMD_RECV16    16'h0040
`define SFW_CMD_RECV8     8'h40
`define SFW_PROTO_TCP     4'h1
`define SFW_PROTO_UDP     4'h2
`define SFW_PROTO_IPRAW   4'h3
`define SFW_PROTO_MACRAW  4'h4
`define SFW_HDR_TCP       4'h2
`define SFW_HDR_UDP       4'h8
`define SFW_HDR_IPRAW     4'h6
`define SFW_HDR_MACRAW    4'h2
`endif

/* File: rtl/sfw_mem.v */
// Word memory with one write port and a registered read port
`timescale 1ns/1ns
module sfw_mem #(
   parameter AW = 12,                     // Word address width
   parameter DW = 16                      // Word width
) (
   input  wire          clk_sys,          // System clock
   input  wire          rst_n,            // Async reset, active low
   input  wire          we,               // Write strobe
   input  wire [AW-1:0] waddr,            // Write word address
   input  wire [DW-1:0] wdata,            // Write word
   input  wire [AW-1:0] raddr,            // Read word address
   output reg  [DW-1:0] rdata             // Read word, one cycle late
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Storage write
   always @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= {DW{1'b0}};
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // sfw_mem

/* File: test/sfw_window_checker.sv */
// Port checker for the socket window block
`timescale 1ns/1ns
module sfw_window_checker (
   input wire        clk_sys,      // System clock
   input wire        rst_n,        // Async reset, active low
   input wire [15:0] host_addr,    // Host byte address
   input wire        host_wr,      // Host write strobe
   input wire        host_rd,      // Host read strobe
   input wire [15:0] host_wdata,   // Host write data
   input wire [15:0] host_rdata,   // Host read data
   input wire [7:0]  tx_out_byte,  // Outgoing byte
   input wire        tx_out_valid, // Outgoing byte valid
   input wire        tx_out_ready, // Outgoing byte taken
   input wire        tx_busy,      // Send in progress
   input wire        rx_pkt_start, // Packet announce
   input wire        rx_busy,      // Packet store in progress
   input wire        rx_pkt_done,  // Packet stored
   input wire        rx_size_dec2, // Received size step
   input wire        rx_done_cmd   // Receive-done command
);
   a_rdata_stands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !host_rd && !$past(host_rd) |=> $stable(host_rdata)) else $error("read data moved");
   a_dec_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_size_dec2 |-> $past(host_rd) && $past(host_addr[15:1]) == 15'h4118)
      else $error("size step without window read");
   a_dec_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_size_dec2 |=> !rx_size_dec2) else $error("size step longer than one cycle");
   a_receive_done_cmd_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_done_cmd |-> $past(host_wr) && $past(host_addr[15:1]) == 15'h4101
      && $past(host_wdata[7:0]) == 8'h40) else $error("receive-done without command");
   a_send_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_busy) |-> $past(host_wr) && $past(host_addr[15:1]) == 15'h4101
      && $past(host_wdata[7:0]) == 8'h20) else $error("send started without command");
   a_send_offer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_busy) |=> tx_out_valid) else $error("first byte not offered");
   a_tx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_byte))
      else $error("offered byte dropped");
   a_tx_in_send: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_out_valid |-> tx_busy) else $error("byte offered while idle");
   a_fill_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rx_busy) |-> $past(rx_pkt_start)) else $error("store without announce");
   a_fill_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rx_busy) |-> ##[2:300] rx_pkt_done) else $error("packet store never ended");
endmodule // sfw_window_checker
bind sfw_window sfw_window_checker sfw_window_checker_inst (.clk_sys(clk_sys),
   .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
   .host_wdata(host_wdata), .host_rdata(host_rdata), .tx_out_byte(tx_out_byte),
   .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_busy(tx_busy),
   .rx_pkt_start(rx_pkt_start), .rx_busy(rx_busy), .rx_pkt_done(rx_pkt_done),
   .rx_size_dec2(rx_size_dec2), .rx_done_cmd(rx_done_cmd));

/* File: test/sfw_host_model.sv */
// Host processor model on the parallel register bus
`timescale 1ns/1ns
module sfw_host_model (
   input  wire        clk_sys,    // System clock
   output reg  [15:0] host_addr,  // Byte address
   output reg         host_wr,    // Write strobe
   output reg         host_rd,    // Read strobe
   output reg  [15:0] host_wdata, // Write data
   input  wire [15:0] host_rdata  // Read data
);
   // Idle bus
   initial begin
      host_addr = 16'hffff;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 16'hffff;
   end
   // One-edge write, lines scrambled once released
   task wr(input [15:0] a, input [15:0] d);
      begin
         @(negedge clk_sys);
         host_addr = a;
         host_wdata = d;
         host_wr = 1'b1;
         @(negedge clk_sys);
         host_wr = 1'b0;
         host_addr = ~a;
         host_wdata = ~d;
      end
   endtask
   // One-edge read, answer taken a cycle later
   task rd(input [15:0] a, output [15:0] d);
      begin
         @(negedge clk_sys);
         host_addr = a;
         host_rd = 1'b1;
         @(negedge clk_sys);
         host_rd = 1'b0;
         host_addr = ~a;
         @(negedge clk_sys);
         d = host_rdata;
      end
   endtask
   // window halves paired, low then high
   task wr8(input [15:0] a, input [7:0] lo, input [7:0] hi);
      begin
         wr(a, {8'h00, lo});
         wr(a | 16'h0001, {8'h00, hi});
      end
   endtask
   // read halves paired the same way
   task rd8(input [15:0] a, output [15:0] lo, output [15:0] hi);
      begin
         rd(a, lo);
         rd(a | 16'h0001, hi);
      end
   endtask
endmodule // sfw_host_model

/* File: test/sfw_window_tb.sv */
// Self-checking bench for the socket window block
`timescale 1ns/1ns
`include "sfw_consts.vh"
module sfw_window_tb;
   reg         clk_sys, rst_n, tx_out_ready, rx_pkt_start, rx_in_valid;
   reg  [16:0] tx_write_size;
   reg  [15:0] rx_pkt_len;
   reg  [47:0] rx_pkt_info;
   reg  [7:0]  rx_in_byte;
   wire [15:0] host_addr, host_wdata, host_rdata;
   wire [7:0]  tx_out_byte;
   wire        host_wr, host_rd, tx_out_valid, tx_busy, rx_in_ready, rx_busy;
   wire        rx_pkt_done, rx_size_dec2, rx_done_cmd;
   integer     bad_count, tests_run, seed, dec_seen, done_seen, dec_exp, i, k, n;
   reg  [7:0]  txq[$];
   reg  [7:0]  rxq[$];
   reg  [15:0] w, w2;
   reg  [3:0]  protos[0:4];
   sfw_window #(.AW(6)) sfw_window_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .tx_write_size(tx_write_size),
      .tx_out_byte(tx_out_byte), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
      .tx_busy(tx_busy), .rx_pkt_start(rx_pkt_start), .rx_pkt_len(rx_pkt_len),
      .rx_pkt_info(rx_pkt_info), .rx_in_byte(rx_in_byte), .rx_in_valid(rx_in_valid),
      .rx_in_ready(rx_in_ready), .rx_busy(rx_busy), .rx_pkt_done(rx_pkt_done),
      .rx_size_dec2(rx_size_dec2), .rx_done_cmd(rx_done_cmd));
   sfw_host_model sfw_host_model_inst (.clk_sys(clk_sys), .host_addr(host_addr),
      .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
      .host_rdata(host_rdata));
   // Clock and pulse counters
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_size_dec2 === 1'b1) dec_seen = dec_seen + 1;
      if (rx_done_cmd === 1'b1) done_seen = done_seen + 1;
   end
   task chk(input string name, input [15:0] exp, input [15:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d, mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Send n queued bytes, sink stalling at random
   task send(input integer n, input [15:0] ca, input [15:0] cd);
      integer t, got;
      begin
         tx_write_size = n[16:0];
         sfw_host_model_inst.wr(ca, cd);
         got = 0;
         for (t = 0; t < 400 && (got < n || tx_busy !== 1'b0); t = t + 1) begin
            @(negedge clk_sys);
            tx_out_ready = $random(seed);
            if (tx_out_ready && tx_out_valid === 1'b1) begin
               if (got >= n) chk("tx extra byte", 16'h0000, {8'h01, tx_out_byte});
               else chk("tx byte", {8'h00, txq.pop_front()}, {8'h00, tx_out_byte});
               got = got + 1;
            end
         end
         if (t >= 400) chk("tx end", 16'h0001, 16'h0000);
         if (n % 2) txq.pop_front();
      end
   endtask
   // Announce and feed one packet, queueing the expected memory bytes
   task rx_pkt(input [3:0] proto, input align, input integer len);
      integer k2, t;
      begin
         rx_pkt_info = {$random(seed), $random(seed)};
         if (proto == `SFW_PROTO_UDP || proto == `SFW_PROTO_IPRAW)
            for (k2 = 5; k2 >= (proto == `SFW_PROTO_UDP ? 0 : 2); k2 = k2 - 1)
               rxq.push_back(rx_pkt_info[8*k2 +: 8]);
         if (!(proto == `SFW_PROTO_TCP && align)) begin
            rxq.push_back(len[15:8]);
            rxq.push_back(len[7:0]);
         end
         @(negedge clk_sys);
         rx_pkt_start = 1'b1;
         rx_pkt_len = len[15:0];
         @(negedge clk_sys);
         rx_pkt_start = 1'b0;
         t = 0;
         for (k2 = 0; k2 < len && t < 300; t = t + 1) begin
            @(negedge clk_sys);
            rx_in_valid = $random(seed);
            rx_in_byte = $random(seed);
            #1;
            if (rx_in_valid && rx_in_ready === 1'b1) begin
               rxq.push_back(rx_in_byte);
               k2 = k2 + 1;
            end
         end
         @(negedge clk_sys);
         rx_in_valid = 1'b0;
         rx_in_byte = ~rx_in_byte;
         if (len % 2) rxq.push_back(8'h00);
         for (t = 0; t < 300 && rx_busy !== 1'b0; t = t + 1) @(negedge clk_sys);
         if (t >= 300) chk("rx store end", 16'h0001, 16'h0000);
      end
   endtask
   initial begin
      #300000;
      bad_count = bad_count + 1;
      finish_test;
   end
   initial begin
      {rst_n, tx_out_ready, rx_pkt_start, rx_in_valid, rx_in_byte} = 0;
      {tx_write_size, rx_pkt_len, rx_pkt_info} = 0;
      {bad_count, tests_run, dec_seen, done_seen, dec_exp} = 0;
      seed = 20;
      protos[0] = `SFW_PROTO_TCP;
      protos[1] = `SFW_PROTO_UDP;
      protos[2] = `SFW_PROTO_IPRAW;
      protos[3] = `SFW_PROTO_MACRAW;
      protos[4] = `SFW_PROTO_TCP;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      chk("tx busy", 16'h0000, {15'h0, tx_busy});
      sfw_host_model_inst.rd(`SFW_MODE_REG, w);
      chk("mode reset", `SFW_MODE_RST, w);
      sfw_host_model_inst.rd(16'h8100, w);
      chk("unmapped read", 16'h0000, w);
      // odd string through the word window, pad dropped on send
      for (k = 0; k < 5; k = k + 1) txq.push_back(8'h61 + k);
      txq.push_back(8'h00);
      for (k = 0; k < 6; k = k + 2) sfw_host_model_inst.wr(`SFW_TX_WIN, {txq[k], txq[k+1]});
      send(5, `SFW_CMD_REG, `SFW_CMD_SEND16);
      // Each protocol mode, then word-wide drain and release
      for (i = 0; i < 5; i = i + 1) begin
         w2 = {7'h00, i == 4, 4'h0, protos[i]};
         sfw_host_model_inst.wr(`SFW_SOCK_MODE_REG, w2);
         // unrelated register read before the receive window
         sfw_host_model_inst.rd(`SFW_SOCK_MODE_REG, w);
         chk("socket mode", w2, w);
         n = $unsigned($random(seed)) % 6 + 1;
         rx_pkt(protos[i], i == 4, n);
         // header then packet, pad read in one word with the last byte
         while (rxq.size() > 0) begin
            sfw_host_model_inst.rd(`SFW_RX_WIN, w);
            w2[15:8] = rxq.pop_front();
            chk("rx word", {w2[15:8], rxq.pop_front()}, w);
            dec_exp = dec_exp + 1;
         end
         sfw_host_model_inst.wr(`SFW_CMD_REG, `SFW_CMD_RECV16);
      end
      // Byte-wide bus, byte-paired windows
      sfw_host_model_inst.wr(`SFW_MODE_REG, 16'h0000);
      sfw_host_model_inst.wr(`SFW_SOCK_MODE_REG, 16'h0000);
      sfw_host_model_inst.wr(`SFW_SOCK_MODE_REG + 16'h1, {12'h0, `SFW_PROTO_TCP});
      for (k = 0; k < 4; k = k + 1) txq.push_back(8'hc0 + k);
      sfw_host_model_inst.wr8(`SFW_TX_WIN, txq[0], txq[1]);
      sfw_host_model_inst.wr8(`SFW_TX_WIN, txq[2], txq[3]);
      send(3, `SFW_CMD_REG + 16'h1, {8'h00, `SFW_CMD_SEND8});
      sfw_host_model_inst.wr8(`SFW_RX_WIN, 8'h56, 8'h78);
      sfw_host_model_inst.rd(`SFW_SOCK_MODE_REG, w);
      rx_pkt(`SFW_PROTO_TCP, 1'b0, 3);
      while (rxq.size() > 0) begin
         sfw_host_model_inst.rd8(`SFW_RX_WIN, w, w2);
         chk("rx low byte", {8'h00, rxq.pop_front()}, w);
         chk("rx high byte", {8'h00, rxq.pop_front()}, w2);
         dec_exp = dec_exp + 1;
      end
      sfw_host_model_inst.wr(`SFW_CMD_REG + 16'h1, {8'h00, `SFW_CMD_RECV8});
      // Memory test: both windows become read-write
      sfw_host_model_inst.wr(`SFW_MODE_REG + 16'h1, 16'h0020);
      sfw_host_model_inst.wr8(`SFW_TX_WIN, 8'ha5, 8'h5a);
      sfw_host_model_inst.rd8(`SFW_TX_WIN, w, w2);
      chk("tx test low", 16'h00a5, w);
      chk("tx test high", 16'h005a, w2);
      sfw_host_model_inst.rd(`SFW_SOCK_MODE_REG, w);
      sfw_host_model_inst.wr8(`SFW_RX_WIN, 8'h12, 8'h34);
      sfw_host_model_inst.rd8(`SFW_RX_WIN, w, w2);
      chk("rx test word", 16'h1234, {w[7:0], w2[7:0]});
      dec_exp = dec_exp + 1;
      // test mode cleared, transmit window reads refused again
      sfw_host_model_inst.wr(`SFW_MODE_REG + 16'h1, 16'h0000);
      sfw_host_model_inst.rd8(`SFW_TX_WIN, w, w2);
      chk("tx refused read", 16'h0000, w | w2);
      chk("size steps", dec_exp[15:0], dec_seen[15:0]);
      chk("receive-done pulses", 16'h0006, done_seen[15:0]);
      finish_test;
   end
endmodule // sfw_window_tb
